// File: hw/dbs_regs.svh
// timing counts, line codes and sizes of the burst sequencer, both ends.
// assumes clk_sys at 4 ns and a lane clock made by the host from it.
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define DBS_SYS_CLK_NS 4
`define DBS_SYS_PER_UI 2
`define DBS_UI_NS (`DBS_SYS_CLK_NS * `DBS_SYS_PER_UI)
`define DBS_LINK_CLK_NS (2 * `DBS_UI_NS)
`define DBS_UP(t, p) (((t) + (p) - 1) / (p))

// ----------------------------------------------------------------
// host side times, ns, and their clk_sys counts, trailer in UI
// ----------------------------------------------------------------
`define DBS_LPX_NS 60
`define DBS_LPX_CYC `DBS_UP(`DBS_LPX_NS, `DBS_SYS_CLK_NS)
`define DBS_PREP_NS 80
`define DBS_PREP_CYC `DBS_UP(`DBS_PREP_NS, `DBS_SYS_CLK_NS)
`define DBS_ZERO_NS 160
`define DBS_ZERO_CYC `DBS_UP(`DBS_ZERO_NS, `DBS_SYS_CLK_NS)
`define DBS_EXIT_NS 120
`define DBS_EXIT_CYC `DBS_UP(`DBS_EXIT_NS, `DBS_SYS_CLK_NS)
`define DBS_TRAIL_NS 96
`define DBS_TRAIL_UI `DBS_UP(`DBS_TRAIL_NS, `DBS_UI_NS)
`define DBS_SYNC_PAT 8'h1d

// ----------------------------------------------------------------
// device side times, ns, and their lane clock counts
// ----------------------------------------------------------------
`define DBS_RX_LPX_NS 50
`define DBS_RX_LPX_CYC `DBS_UP(`DBS_RX_LPX_NS, `DBS_LINK_CLK_NS)
`define DBS_SKIP_NS 48
`define DBS_SKIP_CYC (`DBS_SKIP_NS / `DBS_LINK_CLK_NS)
`define DBS_SYNC_LAG 2
`define DBS_HIST (`DBS_SKIP_CYC + `DBS_SYNC_LAG)
`define DBS_HOLD 4
`define DBS_HB_DEPTH 8

// ----------------------------------------------------------------
// low-power line codes {dp, dn} and buffer
// ----------------------------------------------------------------
`define DBS_LP11 2'h3
`define DBS_LP00 2'h0
`define DBS_FIFO_W 9
`define DBS_FIFO_DEPTH 32

`endif

// File: hw/dbs_pkg.sv
// state types of both lane ends.
// assumes dbs_regs.svh on the include path.
`include "dbs_regs.svh"

package dbs_pkg;

    // ----------------------------------------------------------------
    // host
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        HS_STOP = 7'h01,
        HS_LP01 = 7'h02,
        HS_PREP = 7'h04,
        HS_ZERO = 7'h08,
        HS_SYNC = 7'h10,
        HS_DATA = 7'h20,
        HS_TRAIL = 7'h40
    } dbs_host_e;

    typedef struct packed {
        dbs_host_e st;
        logic ph;
        logic clk_o;
        logic hs_d;
        logic hs_on;
        logic lp_p;
        logic lp_n;
        logic [7:0] cnt;
        logic [2:0] bit_i;
        logic [7:0] cur;
        logic cur_last;
        logic busy;
        logic underrun;
    } dbs_host_s;

    // ----------------------------------------------------------------
    // device
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        DS_STOP = 4'h1,
        DS_HUNT = 4'h2,
        DS_DATA = 4'h4,
        DS_FLUSH = 4'h8
    } dbs_dev_e;

    typedef struct packed {
        dbs_dev_e st;
        logic term;
        logic [2:0] arm;
        logic [9:0] hist;
        logic prev;
        logic [7:0] sr;
        logic [15:0] nbit;
        logic [15:0] lt;
        logic [`DBS_HIST-1:0][15:0] lth;
        logic [`DBS_HB_DEPTH-1:0][7:0] hb;
        logic [12:0] ncomp;
        logic [12:0] nout;
        logic [12:0] nvalid;
        logic out_vld;
        logic [7:0] out_data;
        logic eop;
        logic drop;
    } dbs_dev_s;

endpackage

// File: hw/dbs_lane_if.sv
// one data lane plus its forwarded clock, at the logic level.
// assumes the bench reads these nets directly; no analog levels here.
interface dbs_lane_if;
    logic hs_clk;
    logic hs_data;
    logic hs_drive;
    logic lp_dp;
    logic lp_dn;
    logic term_en;

    modport host (
        output hs_clk,
        output hs_data,
        output hs_drive,
        output lp_dp,
        output lp_dn,
        input term_en
    );

    modport dev (
        input hs_clk,
        input hs_data,
        input hs_drive,
        input lp_dp,
        input lp_dn,
        output term_en
    );
endinterface

// File: hw/dbs_host.sv
// host end: byte fifo and the burst transmitter of one lane.
// assumes clk_sys at 250 MHz; the lane clock is divided from it here.
//
// Contract
// RQ1 - hold LP-00 prepare 40+4UI to 85+6UI
// RQ2 - drive HS-0 at least 105+6UI before sync
// RQ3 - receiver enables termination within 35+4UI
// RQ4 - trailer: inverted last bit, at least 60+4UI
// RQ5 - reach LP-11 within 105+12UI of trailer
// RQ6 - receiver ignores end activity 40 to 55+4UI
// RQ7 - hold LP-11 100 ns before next sequence
// RQ8 - every low-power state lasts 50 ns
// RQ9 - unit interval between 1 and 12.5 ns
// RQ10 - no bit period shorter than one UI
// RQ11 - receiver samples a bit each clock edge
// RQ12 - at most 1 Gbps per lane
// RQ13 - aggregate rate within pixel-format limits
// RQ14 - UI-dependent minimums hold at every rate
// RQ15 - sync sequence lasts eight unit intervals
// RQ16 - align on leader 00011101, else discard
// RQ17 - deliver bytes in order, flag end at LP-11
`include "dbs_regs.svh"

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module dbs_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic in_rdy;
        logic out_vld;
    } dbs_fifo_s;

    dbs_fifo_s s_r;
    dbs_fifo_s s_nxt;
    logic push;
    logic pop;

    always_comb begin
        s_nxt = s_r;
        push = in_valid & s_r.in_rdy;
        pop = out_ready & s_r.out_vld;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = s_r.wp + AW'(1);
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + AW'(1);
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + (AW + 1)'(1);
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - (AW + 1)'(1);
        end
        // flags registered so both handshake outputs come from flops
        s_nxt.in_rdy = (s_nxt.cnt != (AW + 1)'(D));
        s_nxt.out_vld = (s_nxt.cnt != '0);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
            s_r.in_rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign in_ready = s_r.in_rdy;
    assign out_valid = s_r.out_vld;
    assign out_data = s_r.mem[s_r.rp];
endmodule

// ----------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------
module dbs_host (
    // system
    input wire logic clk_sys,
    input wire logic rst,
    // payload bytes in
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    // status
    output logic busy,
    output logic underrun,
    // lane
    dbs_lane_if.host lane
);
    // a literal cannot be bit-selected, so the leader gets a named constant
    localparam logic [7:0] SYNC_PAT = `DBS_SYNC_PAT;

    dbs_pkg::dbs_host_s s_r;
    dbs_pkg::dbs_host_s s_nxt;
    logic [8:0] f_data;
    logic f_vld;
    logic f_pop;
    logic last_bit;

    dbs_fifo #(
        .W(`DBS_FIFO_W),
        .D(`DBS_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_data({tx_last, tx_data}),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(f_data),
        .out_valid(f_vld),
        .out_ready(f_pop)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.underrun = 1'b0;
        last_bit = (s_r.bit_i == 3'h7);
        // one lane at 125 Mbps, far below per-lane and aggregate caps
        s_nxt.ph = ~s_r.ph; // RQ9 RQ12 RQ13
        // clock flips on even phase, data on odd: data sits mid-UI
        if (!s_r.ph) begin
            s_nxt.clk_o = ~s_r.clk_o;
        end
        f_pop = s_r.ph && last_bit && (s_r.st == dbs_pkg::HS_SYNC ||
                (s_r.st == dbs_pkg::HS_DATA && !s_r.cur_last));
        case (s_r.st)
            dbs_pkg::HS_STOP: begin
                s_nxt.busy = 1'b0;
                if (s_r.cnt < 8'(`DBS_EXIT_CYC - 1)) begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end else if (f_vld) begin // RQ7
                    s_nxt.st = dbs_pkg::HS_LP01;
                    s_nxt.lp_p = 1'b0;
                    s_nxt.cnt = 8'h00;
                    s_nxt.busy = 1'b1;
                end
            end
            dbs_pkg::HS_LP01: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == 8'(`DBS_LPX_CYC - 1)) begin // RQ8
                    s_nxt.st = dbs_pkg::HS_PREP;
                    s_nxt.lp_n = 1'b0;
                    s_nxt.cnt = 8'h00;
                end
            end
            dbs_pkg::HS_PREP: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == 8'(`DBS_PREP_CYC - 1)) begin // RQ1 RQ14
                    s_nxt.st = dbs_pkg::HS_ZERO;
                    s_nxt.hs_on = 1'b1;
                    s_nxt.hs_d = 1'b0;
                    s_nxt.cnt = 8'h00;
                end
            end
            dbs_pkg::HS_ZERO: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == 8'(`DBS_ZERO_CYC - 1)) begin // RQ2 RQ14
                    s_nxt.st = dbs_pkg::HS_SYNC;
                    s_nxt.bit_i = 3'h0;
                end
            end
            dbs_pkg::HS_SYNC: begin
                if (s_r.ph) begin
                    // leader goes out msb first in time
                    s_nxt.hs_d = SYNC_PAT[3'h7 - s_r.bit_i]; // RQ15 RQ16
                    s_nxt.bit_i = s_r.bit_i + 3'h1;
                    if (last_bit) begin
                        s_nxt.st = dbs_pkg::HS_DATA;
                        s_nxt.cur = f_data[7:0];
                        s_nxt.cur_last = f_data[8];
                    end
                end
            end
            dbs_pkg::HS_DATA: begin
                if (s_r.ph) begin
                    // one bit per UI, lsb first, never shortened
                    s_nxt.hs_d = s_r.cur[s_r.bit_i]; // RQ10
                    s_nxt.bit_i = s_r.bit_i + 3'h1;
                    if (last_bit) begin
                        if (!s_r.cur_last && f_vld) begin
                            s_nxt.cur = f_data[7:0];
                            s_nxt.cur_last = f_data[8];
                        end else begin
                            // lane cannot pause mid-burst, so a late byte ends it
                            s_nxt.underrun = !s_r.cur_last;
                            s_nxt.st = dbs_pkg::HS_TRAIL;
                            s_nxt.cnt = 8'h00;
                        end
                    end
                end
            end
            dbs_pkg::HS_TRAIL: begin
                if (s_r.ph) begin
                    s_nxt.hs_d = ~s_r.cur[7]; // RQ4
                    s_nxt.cnt = s_r.cnt + 8'h01;
                    if (s_r.cnt == 8'(`DBS_TRAIL_UI)) begin // RQ4 RQ5
                        s_nxt.hs_d = s_r.hs_d;
                        s_nxt.st = dbs_pkg::HS_STOP;
                        s_nxt.hs_on = 1'b0;
                        s_nxt.lp_p = 1'b1;
                        s_nxt.lp_n = 1'b1;
                        s_nxt.cnt = 8'h00;
                    end
                end
            end
            default: begin
                s_nxt.st = dbs_pkg::HS_STOP;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= dbs_pkg::HS_STOP;
            s_r.lp_p <= 1'b1;
            s_r.lp_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign underrun = s_r.underrun;
    assign lane.hs_clk = s_r.clk_o;
    assign lane.hs_data = s_r.hs_d;
    assign lane.hs_drive = s_r.hs_on;
    assign lane.lp_dp = s_r.lp_p;
    assign lane.lp_dn = s_r.lp_n;
endmodule

// File: hw/dbs_dev.sv
// device end: lane receiver, clocked by the forwarded lane clock.
// assumes that clock runs freely; reset arrives from another domain.
`include "dbs_regs.svh"

module dbs_dev (
    // reset, any domain
    input wire logic rst,
    // lane
    dbs_lane_if.dev lane,
    // received payload, lane clock domain
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_eop,
    output logic rx_drop,
    output logic rx_term
);
    dbs_pkg::dbs_dev_s s_r;
    dbs_pkg::dbs_dev_s s_nxt;
    logic [1:0] lp_m;
    logic [1:0] lp_q;
    logic rst_m;
    logic rst_q;
    logic neg_bit;
    logic [9:0] hist_n;

    // ----------------------------------------------------------------
    // synchronisers and falling-edge capture
    // ----------------------------------------------------------------
    always_ff @(posedge lane.hs_clk) begin
        lp_m <= {lane.lp_dp, lane.lp_dn};
        lp_q <= lp_m;
        rst_m <= rst;
        rst_q <= rst_m;
    end

    always_ff @(negedge lane.hs_clk) begin
        neg_bit <= lane.hs_data; // RQ11
    end

    // ----------------------------------------------------------------
    // bit intake
    // ----------------------------------------------------------------
    function automatic dbs_pkg::dbs_dev_s push_bit(input dbs_pkg::dbs_dev_s s,
                                                   input logic b);
        dbs_pkg::dbs_dev_s r;
        r = s;
        r.sr = {b, s.sr[7:1]};
        if (b != s.prev) begin
            r.lt = s.nbit;
        end
        r.prev = b;
        r.nbit = s.nbit + 16'h0001;
        if (s.nbit[2:0] == 3'h7) begin
            r.hb[s.ncomp[2:0]] = {b, s.sr[7:1]};
            r.ncomp = s.ncomp + 13'h0001;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // lane state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.out_vld = 1'b0;
        s_nxt.eop = 1'b0;
        s_nxt.drop = 1'b0;
        // transitions seen inside the skip window never move the end mark
        s_nxt.lth = {s_r.lth[`DBS_HIST-2:0], s_r.lt}; // RQ6
        // older bit from the falling edge, newer from this rising edge
        hist_n = {s_r.hist[7:0], neg_bit, lane.hs_data}; // RQ11
        case (s_r.st)
            dbs_pkg::DS_STOP: begin
                s_nxt.term = 1'b0;
                if (lp_q == `DBS_LP11) begin
                    if (s_r.arm != 3'(`DBS_RX_LPX_CYC)) begin // RQ8
                        s_nxt.arm = s_r.arm + 3'h1;
                    end
                end else if (lp_q == `DBS_LP00) begin
                    s_nxt.arm = 3'h0;
                    if (s_r.arm == 3'(`DBS_RX_LPX_CYC)) begin
                        s_nxt.st = dbs_pkg::DS_HUNT;
                        s_nxt.term = 1'b1; // RQ3
                        s_nxt.hist = 10'h000;
                        s_nxt.nbit = 16'h0000;
                        s_nxt.lt = 16'h0000;
                        s_nxt.lth = '0;
                        s_nxt.ncomp = 13'h0000;
                        s_nxt.nout = 13'h0000;
                    end
                end
            end
            dbs_pkg::DS_HUNT: begin
                s_nxt.hist = hist_n;
                if (lp_q != `DBS_LP00) begin
                    s_nxt.drop = 1'b1; // RQ16
                    s_nxt.st = dbs_pkg::DS_STOP;
                    s_nxt.term = 1'b0;
                end else if (hist_n[7:0] == `DBS_SYNC_PAT) begin // RQ16
                    s_nxt.st = dbs_pkg::DS_DATA;
                    s_nxt.prev = 1'b1;
                end else if (hist_n[8:1] == `DBS_SYNC_PAT) begin // RQ16
                    s_nxt.st = dbs_pkg::DS_DATA;
                    s_nxt.prev = 1'b1;
                    s_nxt = push_bit(s_nxt, lane.hs_data);
                end
            end
            dbs_pkg::DS_DATA: begin
                if (lp_q[1]) begin
                    // payload ends where the trailer's level change began
                    s_nxt.st = dbs_pkg::DS_FLUSH;
                    s_nxt.term = 1'b0;
                    s_nxt.nvalid = s_r.lth[`DBS_HIST-1][15:3]; // RQ6
                end else begin
                    s_nxt = push_bit(push_bit(s_nxt, neg_bit), lane.hs_data);
                    // hold back bytes that may still turn out to be trailer
                    if ((s_nxt.ncomp - s_nxt.nout) > 13'(`DBS_HOLD)) begin // RQ17
                        s_nxt.out_vld = 1'b1;
                        s_nxt.out_data = s_nxt.hb[s_nxt.nout[2:0]];
                        s_nxt.nout = s_nxt.nout + 13'h0001;
                    end
                end
            end
            dbs_pkg::DS_FLUSH: begin
                // stop state seen while flushing arms too, else a quick next burst is lost
                if (lp_q == `DBS_LP11 && s_r.arm != 3'(`DBS_RX_LPX_CYC)) begin // RQ8
                    s_nxt.arm = s_r.arm + 3'h1;
                end
                if (s_r.nout < s_r.nvalid && s_r.nout != s_r.ncomp) begin // RQ17
                    s_nxt.out_vld = 1'b1;
                    s_nxt.out_data = s_r.hb[s_r.nout[2:0]];
                    s_nxt.nout = s_r.nout + 13'h0001;
                end else begin
                    s_nxt.eop = 1'b1; // RQ17
                    s_nxt.st = dbs_pkg::DS_STOP;
                end
            end
            default: begin
                s_nxt.st = dbs_pkg::DS_STOP;
            end
        endcase
    end

    always_ff @(posedge lane.hs_clk) begin
        if (rst_q) begin
            s_r <= '0;
            s_r.st <= dbs_pkg::DS_STOP;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rx_valid = s_r.out_vld;
    assign rx_data = s_r.out_data;
    assign rx_eop = s_r.eop;
    assign rx_drop = s_r.drop;
    assign rx_term = s_r.term;
    assign lane.term_en = s_r.term;
endmodule

// File: dv/dbs_lane_properties.sv
// lane-wire checker between host and device ends.
// assumes clk_sys at 4 ns and the host-made lane clock; instantiated, no bind.
module dbs_lane_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // lane wires
    input wire logic hs_clk,
    input wire logic hs_data,
    input wire logic hs_drive,
    input wire logic lp_dp,
    input wire logic lp_dn,
    input wire logic term_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // helper counters, all in clk_sys edges
    // ----------------------------------------------------------------
    wire logic [2:0] st = {hs_drive, lp_dp, lp_dn};
    logic [2:0] st_r;
    logic [7:0] len_r;
    logic d_r;
    logic [7:0] dl_r;
    logic ck_r;
    logic [3:0] ckl_r;
    logic ck_seen_r;
    logic one_r;
    logic [7:0] z_r;

    // counters saturate so an idle lane never wraps into a short count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= 3'h3;
            len_r <= 8'h00;
            d_r <= 1'b0;
            dl_r <= 8'h00;
            ck_r <= 1'b0;
            ckl_r <= 4'h0;
            ck_seen_r <= 1'b0;
            one_r <= 1'b0;
            z_r <= 8'h00;
        end else begin
            st_r <= st;
            len_r <= (st != st_r) ? 8'h01 : len_r + 8'(len_r != 8'hff);
            d_r <= hs_data;
            dl_r <= (hs_data != d_r) ? 8'h01 : dl_r + 8'(dl_r != 8'hff);
            ck_r <= hs_clk;
            ckl_r <= (hs_clk != ck_r) ? 4'h1 : ckl_r + 4'(ckl_r != 4'hf);
            ck_seen_r <= ck_seen_r | (hs_clk != ck_r);
            one_r <= hs_drive & (one_r | hs_data);
            z_r <= (hs_drive & ~one_r) ? z_r + 8'(z_r != 8'hff) : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_prep_window: assert property (st == 3'h4 && st_r == 3'h0 |-> len_r >= 8'd18 && len_r <= 8'd33)
        else $error("prepare state length out of range");
    a_zero_lead: assert property (hs_drive && hs_data && !one_r |-> z_r >= 8'd45)
        else $error("zero lead too short before sync");
    a_term_on: assert property ($fell(lp_dn) && !lp_dp |-> ##[1:17] term_en)
        else $error("termination not enabled in time");
    a_trail_len: assert property ($fell(hs_drive) |-> dl_r >= 8'd23)
        else $error("trailer too short");
    a_eot_bound: assert property ($fell(hs_drive) |-> lp_dp && lp_dn && dl_r <= 8'd50)
        else $error("stop state late after trailer");
    a_lp_min: assert property (st_r != 3'h4 && st != st_r |-> len_r >= 8'd13)
        else $error("low-power state shorter than minimum");
    a_exit_hold: assert property (st_r == 3'h3 && st != 3'h3 |-> len_r >= 8'd25)
        else $error("stop state left too early");
    a_bit_min: assert property (hs_drive && $past(hs_drive) && hs_data != d_r |-> dl_r >= 8'd2)
        else $error("bit period shorter than one unit interval");
    a_clk_half: assert property (hs_clk != ck_r && ck_seen_r |-> ckl_r == 4'h2)
        else $error("lane clock half period wrong");
    a_data_mid: assert property (hs_drive && $past(hs_drive) && hs_data != d_r |-> hs_clk == ck_r)
        else $error("data changed on a clock edge");
    a_term_off: assert property ($rose(lp_dp) && lp_dn |-> ##[1:17] !term_en)
        else $error("termination held after stop state");
endmodule

// File: dv/dphy_hs_burst_lane_sequencer_tb_top.sv
// bench: host and device joined by one lane, bytes compared end to end.
// assumes the host divides the lane clock from clk_sys; no bench lane clock.
module dphy_hs_burst_lane_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic clk_sys;
    logic rst = 1'b1;
    logic dev_rst = 1'b1;
    logic [7:0] tx_data = 8'h00;
    logic tx_last = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_ready, busy, underrun;
    logic rx_valid, rx_eop, rx_drop, rx_term;
    logic [7:0] rx_data;
    logic [8:0] got;
    logic [8:0] exp_q[$];
    int mismatches = 0;
    int checks_done = 0;
    int seed = 21;
    int un_seen = 0;
    int refused = 0;
    int lens[4] = '{1, 2, 5, 9};

    dbs_lane_if u_lane ();
    dbs_host u_dbs_host (.clk_sys(clk_sys), .rst(rst), .tx_data(tx_data), .tx_last(tx_last),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy), .underrun(underrun),
        .lane(u_lane));
    dbs_dev u_dbs_dev (.rst(dev_rst), .lane(u_lane), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eop(rx_eop), .rx_drop(rx_drop), .rx_term(rx_term));
    dbs_lane_properties u_dbs_lane_properties (.clk_sys(clk_sys), .rst(rst),
        .hs_clk(u_lane.hs_clk), .hs_data(u_lane.hs_data), .hs_drive(u_lane.hs_drive),
        .lp_dp(u_lane.lp_dp), .lp_dn(u_lane.lp_dn), .term_en(u_lane.term_en));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [8:0] exp, input logic [8:0] act);
        checks_done++;
        if (act !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask

    task automatic send(input logic [7:0] d, input logic l);
        @(negedge clk_sys);
        tx_valid = 1'b1;
        tx_data = d;
        tx_last = l;
        while (tx_ready !== 1'b1) begin
            refused++;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        exp_q.push_back({1'b0, d});
        if (l) exp_q.push_back(9'h100);
    endtask

    // without a last byte the host runs dry and must still close the burst
    task automatic burst(input int n, input logic l);
        for (int i = 0; i < n; i++) begin
            send(8'($random(seed)), l && (i == n - 1));
        end
        @(negedge clk_sys);
        tx_valid = 1'b0;
        if (!l) exp_q.push_back(9'h100);
    endtask

    task automatic drain(input string name);
        int n;
        n = 0;
        while ((exp_q.size() != 0 || busy !== 1'b0) && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        cmp(9'h000, 9'(exp_q.size()));
        cmp(9'h000, {8'h00, busy});
        repeat (40) @(negedge clk_sys);
        $display("test %s done", name);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // monitors, sequence and watchdog
    // ----------------------------------------------------------------
    // sampled on the falling lane edge, half a cycle after the outputs move
    always @(negedge u_lane.hs_clk) begin
        got = {rx_eop, rx_valid ? rx_data : 8'h00};
        if (rx_valid === 1'b1 || rx_eop === 1'b1) begin
            cmp(exp_q.size() != 0 ? exp_q.pop_front() : ~got, got);
        end
        if (!dev_rst && rx_drop !== 1'b0) cmp(9'h000, {8'h00, rx_drop});
        if (rx_eop === 1'b1) cmp(9'h000, {8'h00, rx_term});
    end

    always @(negedge clk_sys) begin
        if (underrun === 1'b1) un_seen++;
    end

    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        // device reset needs the lane clock, which runs only after host reset
        repeat (24) @(negedge clk_sys);
        dev_rst = 1'b0;
        repeat (60) @(negedge clk_sys);
        burst(1, 1'b1);
        drain("single");
        foreach (lens[i]) burst(lens[i], 1'b1);
        drain("back_to_back");
        burst(40, 1'b1);
        drain("fill");
        cmp(9'h001, {8'h00, refused != 0});
        cmp(9'h000, 9'(un_seen));
        burst(3, 1'b0);
        drain("underrun");
        cmp(9'h001, 9'(un_seen));
        final_report();
    end

    initial begin
        #200000;
        cmp(9'h000, 9'h1ff);
        final_report();
    end
endmodule
